// ---- shared/dsc_pkg.sv ----
package dsc_pkg;

  // Serial word layout, MSB first on the wire
  localparam int WORD_W    = 16;
  localparam int CMD_W     = 3;
  localparam int CODE_W    = 10;
  localparam int SUB_W     = 3;
  localparam int CMD_MSB   = 15;
  localparam int CMD_LSB   = 13;
  localparam int CODE_MSB  = 12;
  localparam int CODE_LSB  = 3;
  localparam int SUB_MSB   = 2;
  localparam int SUB_LSB   = 0;
  localparam int SYNC_W    = 3;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST  = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [SUB_W-1:0]  SUB_ZERO  = 3'h0;

  // Command field values (low two bits unless noted)
  localparam logic [1:0] CMD_LOAD_BOTH  = 2'h0;
  localparam logic [1:0] CMD_LOAD_INPUT = 2'h1;
  localparam logic [1:0] CMD_UPDATE     = 2'h2;
  localparam logic [2:0] CMD_SHUTDOWN   = 3'h7;
  localparam logic [2:0] CMD_IDLE       = 3'h3;

  // Decoded word carrier
  typedef struct packed {
    logic [CMD_W-1:0]  command_bits;
    logic [CODE_W-1:0] code_bits;
    logic [SUB_W-1:0]  sub_bits;
  } dsc_word_s;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOAD   = 2'h1,
    ACT_BOTH   = 2'h3,
    ACT_UPDATE = 2'h2
  } dsc_act_e;

  typedef enum logic {
    LINK_IDLE   = 1'b0,
    LINK_ACTIVE = 1'b1
  } dsc_link_e;

endpackage

// ---- design/dsc_decoder.sv ----
`timescale 1ns/1ps

module dsc_decoder (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_sclk,
  input  wire logic                        i_din,
  output logic [dsc_pkg::CODE_W-1:0]       o_input_code,
  output logic [dsc_pkg::CODE_W-1:0]       o_dac_code,
  output logic                             o_shutdown,
  output logic                             o_word_strobe,
  output logic                             o_sub_err
);

  // All checks share the core clock and go quiet during reset
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the action logic and the checks
  function automatic dsc_pkg::dsc_act_e decode_act(input logic [dsc_pkg::CMD_W-1:0] cmd);
    dsc_pkg::dsc_act_e act;
    act = dsc_pkg::ACT_NONE;
    if (cmd == dsc_pkg::CMD_SHUTDOWN || cmd == dsc_pkg::CMD_IDLE) begin
      act = dsc_pkg::ACT_NONE;
    end else if (cmd[1:0] == dsc_pkg::CMD_LOAD_BOTH) begin
      act = dsc_pkg::ACT_BOTH;
    end else if (cmd[1:0] == dsc_pkg::CMD_LOAD_INPUT) begin
      act = dsc_pkg::ACT_LOAD;
    end else if (cmd[1:0] == dsc_pkg::CMD_UPDATE) begin
      act = dsc_pkg::ACT_UPDATE;
    end
    return act;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; only stages 2 and 3 are looked at
  logic [dsc_pkg::SYNC_W-1:0] cs_sync_ff;
  logic [dsc_pkg::SYNC_W-1:0] sclk_sync_ff;
  logic [dsc_pkg::SYNC_W-1:0] din_sync_ff;
  logic [dsc_pkg::SYNC_W-1:0] nxt_cs_sync;
  logic [dsc_pkg::SYNC_W-1:0] nxt_sclk_sync;
  logic [dsc_pkg::SYNC_W-1:0] nxt_din_sync;
  logic                       cs_lvl_ff;
  logic                       sclk_lvl_ff;
  logic                       nxt_cs_lvl;
  logic                       nxt_sclk_lvl;

  // A level is accepted only when stages 2 and 3 agree
  always_comb begin
    nxt_cs_sync   = {cs_sync_ff[1:0], i_cs_n};
    nxt_sclk_sync = {sclk_sync_ff[1:0], i_sclk};
    nxt_din_sync  = {din_sync_ff[1:0], i_din};
    nxt_cs_lvl    = (cs_sync_ff[1] == cs_sync_ff[2]) ? cs_sync_ff[2] : cs_lvl_ff;
    nxt_sclk_lvl  = (sclk_sync_ff[1] == sclk_sync_ff[2]) ? sclk_sync_ff[2] : sclk_lvl_ff;
  end

  // Select idles high so no edge is seen out of reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync_ff   <= '1;
      sclk_sync_ff <= '0;
      din_sync_ff  <= '0;
      cs_lvl_ff    <= 1'b1;
      sclk_lvl_ff  <= 1'b0;
    end else begin
      cs_sync_ff   <= nxt_cs_sync;
      sclk_sync_ff <= nxt_sclk_sync;
      din_sync_ff  <= nxt_din_sync;
      cs_lvl_ff    <= nxt_cs_lvl;
      sclk_lvl_ff  <= nxt_sclk_lvl;
    end
  end

  logic sclk_rise;
  logic cs_rise;
  // Edge is seen the cycle a new level is accepted; idle reset levels avoid a false edge
  assign sclk_rise = nxt_sclk_lvl & ~sclk_lvl_ff;
  assign cs_rise   = nxt_cs_lvl & ~cs_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link state and shift register
  dsc_pkg::dsc_link_e              link_ff;
  dsc_pkg::dsc_link_e              nxt_link;
  logic [dsc_pkg::WORD_W-1:0]      shift_ff;
  logic [dsc_pkg::WORD_W-1:0]      nxt_shift;

  // Data stage 3 is sampled with the same lag as the clock edge decision
  always_comb begin
    nxt_link  = link_ff;
    nxt_shift = shift_ff;
    unique case (link_ff)
      dsc_pkg::LINK_IDLE: begin
        if (!nxt_cs_lvl) begin
          nxt_link = dsc_pkg::LINK_ACTIVE;
        end
      end
      dsc_pkg::LINK_ACTIVE: begin
        if (nxt_cs_lvl) begin
          nxt_link = dsc_pkg::LINK_IDLE;
        end else if (sclk_rise) begin
          // Keeps only the newest sixteen bits on any edge count
          nxt_shift = {shift_ff[dsc_pkg::WORD_W-2:0], din_sync_ff[2]};
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      link_ff  <= dsc_pkg::LINK_IDLE;
      shift_ff <= dsc_pkg::WORD_RST;
    end else begin
      link_ff  <= nxt_link;
      shift_ff <= nxt_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution at the select rising edge
  dsc_pkg::dsc_word_s          word;
  dsc_pkg::dsc_act_e           act;
  logic                        word_go;
  logic [dsc_pkg::CODE_W-1:0]  input_ff;
  logic [dsc_pkg::CODE_W-1:0]  dac_ff;
  logic                        sd_ff;
  logic                        strobe_ff;
  logic                        sub_err_ff;
  logic [dsc_pkg::CODE_W-1:0]  nxt_input;
  logic [dsc_pkg::CODE_W-1:0]  nxt_dac;
  logic                        nxt_sd;
  logic                        nxt_sub_err;

  // Word decoded straight from the shift register; no bit counter is kept
  assign word    = shift_ff;
  assign act     = decode_act(word.command_bits);
  assign word_go = cs_rise && (link_ff == dsc_pkg::LINK_ACTIVE);

  always_comb begin
    nxt_input   = input_ff;
    nxt_dac     = dac_ff;
    nxt_sd      = sd_ff;
    nxt_sub_err = sub_err_ff;
    if (word_go) begin
      if (word.command_bits == dsc_pkg::CMD_SHUTDOWN) begin
        nxt_sd = 1'b1;
      end
      unique case (act)
        dsc_pkg::ACT_BOTH: begin
          nxt_input = word.code_bits;
          nxt_dac   = word.code_bits;
          nxt_sd    = 1'b0;
        end
        dsc_pkg::ACT_LOAD: begin
          nxt_input = word.code_bits;
        end
        dsc_pkg::ACT_UPDATE: begin
          nxt_dac = input_ff;
          nxt_sd  = 1'b0;
        end
        dsc_pkg::ACT_NONE: begin
          nxt_input = input_ff;
        end
      endcase
      // Sub-bits should be zero on loads; flagged, not refused
      if (act == dsc_pkg::ACT_BOTH || act == dsc_pkg::ACT_LOAD) begin
        nxt_sub_err = (word.sub_bits != dsc_pkg::SUB_ZERO);
      end
    end
  end

  // Power-on clears both code registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      input_ff   <= dsc_pkg::CODE_RST;
      dac_ff     <= dsc_pkg::CODE_RST;
      sd_ff      <= 1'b0;
      strobe_ff  <= 1'b0;
      sub_err_ff <= 1'b0;
    end else begin
      input_ff   <= nxt_input;
      dac_ff     <= nxt_dac;
      sd_ff      <= nxt_sd;
      strobe_ff  <= word_go;
      sub_err_ff <= nxt_sub_err;
    end
  end

  // Every output comes from a register
  assign o_input_code  = input_ff;
  assign o_dac_code    = dac_ff;
  assign o_shutdown    = sd_ff;
  assign o_word_strobe = strobe_ff;
  assign o_sub_err     = sub_err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_go_update;
    word_go && act == dsc_pkg::ACT_UPDATE;
  endsequence

  a_update_copies: assert property (
    s_go_update |=> (dac_ff == $past(input_ff)) && !sd_ff)
    else $error("update did not copy input to dac");

  a_shutdown_enter: assert property (
    word_go && word.command_bits == dsc_pkg::CMD_SHUTDOWN |=>
      sd_ff && $stable(dac_ff) && $stable(input_ff))
    else $error("shutdown not entered");

  a_idle_keeps: assert property (
    word_go && word.command_bits == dsc_pkg::CMD_IDLE |=>
      $stable(input_ff) && $stable(dac_ff) && $stable(sd_ff))
    else $error("idle command changed state");

  a_load_both: assert property (
    word_go && act == dsc_pkg::ACT_BOTH |=>
      dac_ff == $past(word.code_bits) && input_ff == dac_ff && !sd_ff)
    else $error("load both wrong");

  a_load_input: assert property (
    word_go && act == dsc_pkg::ACT_LOAD |=>
      input_ff == $past(word.code_bits) && $stable(dac_ff))
    else $error("load input wrong");

  a_only_at_edge: assert property (
    !word_go |=> $stable(input_ff) && $stable(dac_ff) && $stable(sd_ff))
    else $error("registers changed without select edge");

  a_shift_idle: assert property (
    link_ff == dsc_pkg::LINK_IDLE |=> $stable(shift_ff))
    else $error("shift while select high");

  a_shift_newest: assert property (
    link_ff == dsc_pkg::LINK_ACTIVE && !nxt_cs_lvl && sclk_rise |=>
      shift_ff[0] == $past(din_sync_ff[2]) &&
      shift_ff[dsc_pkg::WORD_W-1:1] == $past(shift_ff[dsc_pkg::WORD_W-2:0]))
    else $error("shift did not keep newest bits");

  a_strobe_pulse: assert property (
    o_word_strobe |=> !o_word_strobe)
    else $error("word strobe longer than one cycle");

endmodule

// ---- bench/dsc_host.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host side of the three-wire link; each converter would get its own select
module dsc_host (
  input  wire logic i_core_clk,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  // Idle: select high, clock parked low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shift the low n bits of w, MSB first; data settles 200 ns before each rise
  task automatic shift(input logic [19:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge i_core_clk);
      o_cs_n <= 1'b0;
      o_din  <= w[i];
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_core_clk);
    end
  endtask

  // Close the frame late enough that the last rise is surely seen
  task automatic finish();
    @(posedge i_core_clk);
    o_sclk <= 1'b0;
    o_din  <= ~o_din; // Released data must not keep its last value
    repeat (6) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic                       i_core_clk;
  logic                       i_rst;
  logic                       cs_n;
  logic                       sclk;
  logic                       din;
  logic [dsc_pkg::CODE_W-1:0] input_code;
  logic [dsc_pkg::CODE_W-1:0] dac_code;
  logic                       shutdown;
  logic                       word_strobe;
  logic                       sub_err;
  logic [9:0]                 e_in;
  logic [9:0]                 e_dac;
  logic                       e_sd;
  logic                       e_err;
  int                         n_fail;
  int                         n_tests;

  dsc_host host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  dsc_decoder uut (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_cs_n       (cs_n),
    .i_sclk       (sclk),
    .i_din        (din),
    .o_input_code (input_code),
    .o_dac_code   (dac_code),
    .o_shutdown   (shutdown),
    .o_word_strobe(word_strobe),
    .o_sub_err    (sub_err)
  );

  // 20 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare the code, shutdown and sub-error outputs (not the word strobe) against the expected state
  task automatic chk(input string what);
    n_tests++;
    if ({input_code, dac_code, shutdown, sub_err} !== {e_in, e_dac, e_sd, e_err}) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h %h %b %b exp %h %h %b %b", $time, what,
               input_code, dac_code, shutdown, sub_err, e_in, e_dac, e_sd, e_err);
    end
  endtask

  // One frame; the word acted on is the last 16 bits shifted, the low 16 bits of w when n is 16 or more
  task automatic send(input logic [19:0] w, input int n);
    logic [2:0] c;
    int         k;
    c = w[15:13];
    host.shift(w, n);
    #1;
    chk("before select rise");
    host.finish();
    if (c[1] == 1'b0) begin
      e_in  = w[12:3];
      e_err = (w[2:0] != 3'h0);
    end
    if (c[1:0] == 2'h0) begin
      e_dac = w[12:3];
      e_sd  = 1'b0;
    end
    if (c[1:0] == 2'h2) begin
      e_dac = e_in;
      e_sd  = 1'b0;
    end
    if (c == 3'h7)
      e_sd = 1'b1;
    // Bounded wait for the execution pulse
    for (k = 0; k < 20 && word_strobe !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (word_strobe !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t no word strobe", $time);
      results();
    end
    chk("after word");
    repeat (6) @(posedge i_core_clk); // Select stays high 300 ns or more
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: each command code, boundary codes, 20-bit and 8-bit frames
  initial begin
    n_fail  = 0;
    n_tests = 0;
    {e_in, e_dac, e_sd, e_err} = '0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    #1;
    chk("reset");
    send({4'h0, 3'b000, 10'h3ff, 3'h0}, 16);
    send({4'h0, 3'b001, 10'h155, 3'h0}, 16);
    send({4'h0, 3'b111, 10'h2aa, 3'h5}, 16);
    send({4'h0, 3'b011, 10'h0f0, 3'h7}, 16);
    send({4'h0, 3'b010, 10'h0ff, 3'h0}, 16);
    send({4'h0, 3'b111, 10'h000, 3'h0}, 16);
    send({4'h0, 3'b100, 10'h200, 3'h0}, 16);
    send({4'h0, 3'b110, 10'h111, 3'h2}, 16);
    send({4'h0, 3'b101, 10'h001, 3'h6}, 16);
    send({4'hf, 3'b000, 10'h000, 3'h0}, 20);
    send(20'h00028, 8);
    results();
  end
endmodule
